// ### core/dpwf_pkg.sv
`default_nettype none
package dpwf_pkg;
	// Reference clock period in picoseconds
	localparam int CLK_PS = 4000;
	// Device times in ns, slower grade, which also covers the faster grade
	localparam int T_WP_NS = 12;
	localparam int T_DW_NS = 10;
	localparam int T_WR_NS = 0;
	localparam int T_SWRD_NS = 5;
	localparam int T_WH_NS = 12;
	localparam int T_AA_NS = 15;
	localparam int T_BDD_NS = 17;
	localparam int T_HZ_NS = 12;

	// Least time rounded up to whole cycles, never below one
	function automatic int dpwf_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction : dpwf_cyc

	localparam logic [3:0] WP_CYC = 4'(dpwf_cyc(T_WP_NS));
	localparam logic [3:0] WR_CYC = 4'(dpwf_cyc(T_WR_NS));
	localparam logic [3:0] SWRD_CYC = 4'(dpwf_cyc(T_SWRD_NS));
	localparam logic [3:0] WH_CYC = 4'(dpwf_cyc(T_WH_NS));
	localparam logic [3:0] RD_CYC = 4'(dpwf_cyc(T_AA_NS));
	localparam logic [3:0] BDD_CYC = 4'(dpwf_cyc(T_BDD_NS));
	localparam logic [3:0] HZ_CYC = 4'(dpwf_cyc(T_HZ_NS));

	localparam int ADDR_W = 15;
	localparam int DATA_W = 16;
	// Semaphore flag is chosen by the low address bits, written via bit 0
	localparam int SEM_SEL_W = 3;
	localparam int SEM_BIT = 0;

	// User commands
	typedef enum logic [1:0] {
		DPWF_RAM_WR = 2'h0,
		DPWF_RAM_RD = 2'h1,
		DPWF_SEM_WR = 2'h2,
		DPWF_SEM_RD = 2'h3
	} dpwf_cmd_t;
endpackage : dpwf_pkg
`default_nettype wire

// ### core/dpwf_host.sv
// Summary of operation
// - Write happens while select and strobe low
// - Strobes high whenever the address changes
// - Array or flag select, never both
// - Write data valid before write ends
// - Never drive data while device drives
// - Output gate low stretches strobe pulse
// - Recovery counted from earlier rising edge
// - Wait before reading a written flag
// - Close flag writes give undetermined winner
// - Earlier stable port wins master arbitration
// - Slave contention input leads the write
// - Hold strobe after contention flag release
// - Wait after flag release before data
// - Chip select high during flag sequence
`default_nettype none
module dpwf_host (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic req,
	output logic ready,
	input wire dpwf_pkg::dpwf_cmd_t cmd,
	input wire logic [dpwf_pkg::ADDR_W-1:0] addr,
	input wire logic [dpwf_pkg::DATA_W-1:0] wdata,
	input wire logic [1:0] byte_en,
	output logic [dpwf_pkg::DATA_W-1:0] rdata,
	output logic done,
	output logic ce_n,
	output logic rw_n,
	output logic oe_n,
	output logic upper_byte_sel_n,
	output logic lower_byte_sel_n,
	output logic flag_access_n,
	output logic [dpwf_pkg::ADDR_W-1:0] mem_addr,
	output logic [dpwf_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [dpwf_pkg::DATA_W-1:0] dq_in,
	input wire logic busy_n
);
	import dpwf_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer state
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_WRITE = 3'h2,
		ST_HOLD = 3'h3,
		ST_READ = 3'h4,
		ST_RECOV = 3'h5
	} dpwf_state_t;

	dpwf_state_t state_reg, state_next; // Phase of the access
	logic [3:0] cnt_reg, cnt_next; // Cycles left in the phase
	dpwf_cmd_t cmd_reg, cmd_next; // Latched command
	logic [1:0] be_reg, be_next; // Latched byte enables, active high
	logic ce_n_reg, ce_n_next;
	logic rw_n_reg, rw_n_next;
	logic oe_n_reg, oe_n_next;
	logic ub_n_reg, ub_n_next;
	logic lb_n_reg, lb_n_next;
	logic flag_n_reg, flag_n_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] dq_reg, dq_next;
	logic dq_oe_reg, dq_oe_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic done_reg, done_next;

	// Semaphore commands never assert chip select
	function automatic logic is_sem(input dpwf_cmd_t c);
		return (c == DPWF_SEM_WR) || (c == DPWF_SEM_RD);
	endfunction : is_sem

	assign ready = (state_reg == ST_IDLE);
	assign rdata = rdata_reg;
	assign done = done_reg;
	assign ce_n = ce_n_reg;
	assign rw_n = rw_n_reg;
	assign oe_n = oe_n_reg;
	assign upper_byte_sel_n = ub_n_reg;
	assign lower_byte_sel_n = lb_n_reg;
	assign flag_access_n = flag_n_reg;
	assign mem_addr = addr_reg;
	assign dq_out = dq_reg;
	assign dq_oe = dq_oe_reg;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic; every pin comes from a flop so no glitch reaches it
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cmd_next = cmd_reg;
		be_next = be_reg;
		ce_n_next = ce_n_reg;
		rw_n_next = rw_n_reg;
		oe_n_next = oe_n_reg;
		ub_n_next = ub_n_reg;
		lb_n_next = lb_n_reg;
		flag_n_next = flag_n_reg;
		addr_next = addr_reg;
		dq_next = dq_reg;
		dq_oe_next = dq_oe_reg;
		rdata_next = rdata_reg;
		done_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// address before selects
				// Address settles a cycle ahead of the select, so arbitration sees it stable
				// address moves
				// Address only moves here, with every strobe high
				if (req) begin
					cmd_next = cmd;
					be_next = byte_en;
					addr_next = addr;
					dq_next = wdata;
					state_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// select choice
				// Exactly one of chip select and flag access goes low
				ce_n_next = is_sem(cmd_reg);
				flag_n_next = !is_sem(cmd_reg);
				// Semaphore uses both bytes; flag selected by addr low bits
				// flag address
				ub_n_next = is_sem(cmd_reg) ? 1'b0 : !be_reg[1];
				lb_n_next = is_sem(cmd_reg) ? 1'b0 : !be_reg[0];
				if (cmd_reg == DPWF_RAM_WR || cmd_reg == DPWF_SEM_WR) begin
					// strobe with select
					// Strobe falls with the select, so device outputs stay off
					rw_n_next = 1'b0;
					// no bus fight
					// Output gate held high, so our data may go out at once
					dq_oe_next = 1'b1;
					cnt_next = WP_CYC - 4'h1;
					state_next = ST_WRITE;
				end else begin
					oe_n_next = 1'b0;
					cnt_next = RD_CYC - 4'h1;
					state_next = ST_READ;
				end
			end
			ST_WRITE: begin
				// gate high
				// Data is valid for the whole pulse; gate never low here
				if (cmd_reg == DPWF_RAM_WR && !busy_n) begin
					// discarded write
					// Device drops the write while contention flag is low
					cnt_next = WH_CYC - 4'h1;
					state_next = ST_HOLD;
				end else if (cnt_reg == 4'h0) begin
					state_next = ST_RECOV;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			ST_HOLD: begin
				// slave input leads
				// Keep strobe low until the flag has been high long enough
				if (!busy_n) begin
					cnt_next = WH_CYC - 4'h1;
				end else if (cnt_reg == 4'h0) begin
					state_next = ST_RECOV;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			ST_READ: begin
				// wait after release
				// Opposite writer unknown, so any contention in an array read restarts the wait; flag reads ignore it
				if (!is_sem(cmd_reg) && !busy_n) begin
					cnt_next = BDD_CYC - 4'h1;
				end else if (cnt_reg == 4'h0) begin
					// flag on all lines
					// All enables fell together; count covers the slowest
					rdata_next = dq_in;
					state_next = ST_RECOV;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			ST_RECOV: begin
				if (rw_n_reg == 1'b0 || oe_n_reg == 1'b0) begin
					// First recovery cycle: all strobes rise together
					done_next = 1'b1;
					ce_n_next = 1'b1;
					flag_n_next = 1'b1;
					rw_n_next = 1'b1;
					oe_n_next = 1'b1;
					ub_n_next = 1'b1;
					lb_n_next = 1'b1;
					dq_oe_next = 1'b0;
					// one release edge
					// All strobes rise together: one reference edge for flag contention
					// flag write to read
					// select stays high
					// Gap after a flag write; after a read, let outputs float
					if (cmd_reg == DPWF_SEM_WR) begin
						cnt_next = SWRD_CYC - 4'h1;
					end else if (!oe_n_reg) begin
						cnt_next = HZ_CYC - 4'h1;
					end else begin
						cnt_next = WR_CYC - 4'h1;
					end
				end else if (cnt_reg == 4'h0) begin
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// State registers; reset leaves the port deselected and bus released
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			cmd_reg <= DPWF_RAM_RD;
			be_reg <= 2'h0;
			ce_n_reg <= 1'b1;
			rw_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			ub_n_reg <= 1'b1;
			lb_n_reg <= 1'b1;
			flag_n_reg <= 1'b1;
			addr_reg <= '0;
			dq_reg <= '0;
			dq_oe_reg <= 1'b0;
			rdata_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cmd_reg <= cmd_next;
			be_reg <= be_next;
			ce_n_reg <= ce_n_next;
			rw_n_reg <= rw_n_next;
			oe_n_reg <= oe_n_next;
			ub_n_reg <= ub_n_next;
			lb_n_reg <= lb_n_next;
			flag_n_reg <= flag_n_next;
			addr_reg <= addr_next;
			dq_reg <= dq_next;
			dq_oe_reg <= dq_oe_next;
			rdata_reg <= rdata_next;
			done_reg <= done_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks on the pins this port drives
	default clocking dpwf_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	sequence gate_off_3;
		oe_n_reg && $past(oe_n_reg) && $past(oe_n_reg, 2) && $past(oe_n_reg, 3);
	endsequence
	sequence flag_wr_end;
		$rose(rw_n_reg) && $past(!flag_n_reg);
	endsequence

	addr_stable_a: assert property ($changed(addr_reg) |-> rw_n_reg && $past(rw_n_reg))
		else $error("address moved while strobe low");
	sel_excl_a: assert property (!(!ce_n_reg && !flag_n_reg))
		else $error("chip select and flag access both low");
	write_sel_a: assert property (!rw_n_reg |-> !ce_n_reg || !flag_n_reg)
		else $error("strobe low without a select");
	wr_pulse_a: assert property ($fell(rw_n_reg) |-> !rw_n_reg [*3])
		else $error("write pulse too short");
	write_gate_a: assert property (!rw_n_reg |-> oe_n_reg && dq_oe_reg)
		else $error("output gate low or data off in write");
	dq_drive_a: assert property ($rose(dq_oe_reg) |-> gate_off_3)
		else $error("data driven too soon after read");
	sem_gap_a: assert property (flag_wr_end |-> flag_n_reg [*2])
		else $error("flag read too soon after flag write");
	sem_ce_a: assert property (!flag_n_reg |-> ce_n_reg)
		else $error("chip select low during flag access");
	busy_hold_a: assert property ($rose(busy_n) && !rw_n_reg |-> !rw_n_reg [*3])
		else $error("strobe released too soon after flag");
	rd_wait_a: assert property ($fell(oe_n_reg) |-> !oe_n_reg [*4])
		else $error("read shorter than access time");
	rd_bdd_a: assert property ($rose(busy_n) && !oe_n_reg && !ce_n_reg |-> !oe_n_reg [*5])
		else $error("read ended before flag-to-data delay");
endmodule : dpwf_host
`default_nettype wire

// ### dv/dpwf_dev_model.sv
`default_nettype none
// Behavioural memory port: small array, eight flags, contention flag
module dpwf_dev_model (
	input wire logic ref_clk,
	input wire logic ce_n,
	input wire logic rw_n,
	input wire logic oe_n,
	input wire logic upper_byte_sel_n,
	input wire logic lower_byte_sel_n,
	input wire logic flag_access_n,
	input wire logic [dpwf_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [dpwf_pkg::DATA_W-1:0] dq_out,
	input wire logic hold_busy,
	output logic [dpwf_pkg::DATA_W-1:0] dq_in,
	output logic busy_n,
	output logic dev_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	import dpwf_pkg::*;
	// Only sixteen words: tests use low addresses
	logic [15:0] mem [0:15];
	logic [7:0] flags_reg = 8'hFF;
	// Last driven word, inverted on a released bus
	logic [15:0] last_q = 16'h0000;
	////////////////////////////////////////////////////////////////////////////
	// contention follows select
	assign busy_n = ~(hold_busy & ~ce_n);
	assign dev_drv = ~oe_n & rw_n & (~ce_n | ~flag_access_n);
	assign dq_in = !dev_drv ? ~last_q :
		(!flag_access_n ? {16{flags_reg[mem_addr[2:0]]}} : mem[mem_addr[3:0]]);
	////////////////////////////////////////////////////////////////////////////
	// port-to-port at once
	// Array writes land at each edge of the overlap while busy_n is high, flag writes at every edge; the last one wins
	always @(posedge ref_clk) begin
		if (dev_drv) begin
			last_q <= dq_in;
		end
		if (!rw_n && !ce_n && busy_n) begin
			if (!upper_byte_sel_n) mem[mem_addr[3:0]][15:8] <= dq_out[15:8];
			if (!lower_byte_sel_n) mem[mem_addr[3:0]][7:0] <= dq_out[7:0];
		end
		if (!rw_n && !flag_access_n) begin
			flags_reg[mem_addr[2:0]] <= dq_out[0];
		end
	end
endmodule : dpwf_dev_model
`default_nettype wire

// ### dv/test_dual_port_write_flag_arbitration.sv
`default_nettype none
module test_dual_port_write_flag_arbitration;
	timeunit 1ns;
	timeprecision 1ps;
	import dpwf_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic req = 1'b0;
	logic ready, done, ce_n, rw_n, oe_n, ub_n, lb_n, fa_n, dq_oe, busy_n, dev_drv;
	dpwf_cmd_t cmd = DPWF_RAM_RD;
	logic [14:0] addr = 15'h0000;
	logic [14:0] mem_addr;
	logic [14:0] last_addr = 15'h0000;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata, dq_out, dq_in;
	logic [1:0] byte_en = 2'h0;
	logic hold_busy = 1'b0;
	int n_errors = 0;
	int n_checks = 0;
	int lat;
	always #2 ref_clk = ~ref_clk;
	dpwf_host uut (.ref_clk(ref_clk), .rstn(rstn), .req(req), .ready(ready), .cmd(cmd),
		.addr(addr), .wdata(wdata), .byte_en(byte_en), .rdata(rdata), .done(done),
		.ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .upper_byte_sel_n(ub_n),
		.lower_byte_sel_n(lb_n), .flag_access_n(fa_n), .mem_addr(mem_addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .busy_n(busy_n));
	dpwf_dev_model dev (.ref_clk(ref_clk), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n),
		.upper_byte_sel_n(ub_n), .lower_byte_sel_n(lb_n), .flag_access_n(fa_n),
		.mem_addr(mem_addr), .dq_out(dq_out), .hold_busy(hold_busy), .dq_in(dq_in),
		.busy_n(busy_n), .dev_drv(dev_drv));
	////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// One request; lat counts edges from the taking edge to the done pulse
	task automatic op(input dpwf_cmd_t c, input logic [14:0] a, input logic [15:0] d,
		input logic [1:0] be);
		int i;
		for (i = 0; i < 20 && ready !== 1'b1; i++) @(posedge ref_clk);
		// A port that never comes back to idle is a failure, not a wait
		if (i >= 20) begin
			n_errors++;
			give_verdict();
		end
		@(posedge ref_clk);
		req <= 1'b1;
		cmd <= c;
		addr <= a;
		wdata <= d;
		byte_en <= be;
		@(posedge ref_clk);
		req <= 1'b0;
		for (lat = 1; lat < 40; lat++) begin
			@(posedge ref_clk);
			#1;
			if (done === 1'b1) break;
		end
		if (lat >= 40) begin
			n_errors++;
			give_verdict();
		end
	endtask : op
	////////////////////////////////////////////////////////////////////////////
	// Pin watch: a shared bus or a moving address would corrupt the array
	always @(posedge ref_clk) begin
		#1;
		if (dq_oe === 1'b1 && dev_drv === 1'b1) check("bus_clash", 16'h1, 16'h0);
		if (mem_addr !== last_addr && !rw_n && !ce_n && !(ub_n && lb_n))
			check("addr_move", 16'h1, 16'h0);
		if (!ce_n && !fa_n) check("both_sel", 16'h1, 16'h0);
		last_addr = mem_addr;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check("idle_pins", {9'h0, ce_n, rw_n, oe_n, ub_n, lb_n, fa_n, dq_oe},
			16'h007E);
		check("idle_ready", {15'h0, ready}, 16'h0001);
	endtask : t_reset
	task automatic t_ram;
		op(DPWF_RAM_WR, 15'h0005, 16'hA5C3, 2'b11);
		// Setup edge, three strobe cycles, then the edge that raises the strobes
		check("wr_lat", lat[15:0], 16'h0005);
		op(DPWF_RAM_WR, 15'h0005, 16'h3C00, 2'b10);
		op(DPWF_RAM_RD, 15'h0005, 16'h0000, 2'b11);
		// Setup edge, four access cycles, then the edge that raises the strobes
		check("rd_lat", lat[15:0], 16'h0006);
		check("rd_bytes", rdata, 16'h3CC3);
	endtask : t_ram
	task automatic t_flags;
		int i;
		for (i = 0; i < 8; i++) op(DPWF_SEM_WR, 15'(i) | 15'h0010, 16'hFFFE | 16'(i & 1), 2'b00);
		for (i = 0; i < 8; i++) begin
			op(DPWF_SEM_RD, 15'(i), 16'h0000, 2'b00);
			check("flag_rd", rdata, {16{i[0]}});
		end
	endtask : t_flags
	task automatic t_busy_wr;
		op(DPWF_RAM_WR, 15'h0003, 16'h1111, 2'b11);
		hold_busy <= 1'b1;
		fork
			op(DPWF_RAM_WR, 15'h0003, 16'h5A5A, 2'b11);
			begin
				repeat (8) @(posedge ref_clk);
				hold_busy <= 1'b0;
			end
		join
		// Flag seen high at edge 5, three hold cycles, strobes rise at edge 8
		check("busy_hold", lat[15:0], 16'h0008);
		op(DPWF_RAM_RD, 15'h0003, 16'h0000, 2'b11);
		check("busy_data", rdata, 16'h5A5A);
	endtask : t_busy_wr
	task automatic t_busy_rd;
		hold_busy <= 1'b1;
		fork
			op(DPWF_RAM_RD, 15'h0005, 16'h0000, 2'b11);
			begin
				// Release at edge 3 of the read, after the select has fallen
				repeat (9) @(posedge ref_clk);
				hold_busy <= 1'b0;
			end
		join
		// Flag seen high at edge 4, five settle cycles, strobes rise at edge 9
		check("busy_rd_lat", lat[15:0], 16'h0009);
		check("busy_rd", rdata, 16'h3CC3);
	endtask : t_busy_rd
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		#1;
		t_reset();
		t_ram();
		t_flags();
		t_busy_wr();
		t_busy_rd();
		give_verdict();
	end
endmodule : test_dual_port_write_flag_arbitration
`default_nettype wire
